// ---- ols_pkg.sv ----
`default_nettype none
package ols_pkg;

  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int unsigned NCH           = 8;
  localparam int unsigned FRAME_BITS    = 16;
  localparam logic [4:0]  FRAME_BITS_C  = 5'h10;
  localparam logic [4:0]  BITS_SAT      = 5'h1F;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned SCLK_MAX_MHZ  = 8;
  localparam int unsigned DIAG_STEP_US  = 20;
  localparam int unsigned DIAG_STEP_CYC = DIAG_STEP_US * CLK_MHZ;
  localparam int unsigned PWM_STEP_US   = 10;
  localparam int unsigned PWM_STEP_CYC  = PWM_STEP_US * CLK_MHZ;
  localparam int unsigned RETRY_US      = 1000;
  localparam int unsigned LIMP_CH0      = 2;
  localparam int unsigned LIMP_CH1      = 3;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [3:0] A_OUT   = 4'h0;
  localparam logic [3:0] A_MAP0  = 4'h1;
  localparam logic [3:0] A_MAP1  = 4'h2;
  localparam logic [3:0] A_PWM0  = 4'h3;
  localparam logic [3:0] A_PWM1  = 4'h4;
  localparam logic [3:0] A_DUTY  = 4'h5;
  localparam logic [3:0] A_CFG   = 4'h6;
  localparam logic [3:0] A_OVLD  = 4'h8;
  localparam logic [3:0] A_HOT   = 4'h9;
  localparam logic [3:0] A_OPEN  = 4'hA;
  localparam logic [3:0] A_SHORT = 4'hB;
  localparam logic [3:0] A_STAT  = 4'hC;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned B_UV_MASK  = 0;
  localparam int unsigned B_DCH_LO   = 1;
  localparam int unsigned B_DIAG_GO  = 7;
  localparam logic [7:0]  MAP0_RST   = 8'h04;
  localparam logic [7:0]  MAP1_RST   = 8'h08;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [15:0] RESP_RST   = 16'h0001;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [1:0] cnt;
    logic [7:0] data;
    logic       par;
  } ols_frame_t;

  typedef struct packed {
    logic       err;
    logic [3:0] addr;
    logic [1:0] cnt;
    logic [7:0] data;
    logic       par;
  } ols_resp_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       si;
    logic       cmd0;
    logic       cmd1;
    logic       idle_n;
    logic       kill;
    logic       bat_low;
    logic       lsup_ok;
    logic [7:0] ovld;
    logic [7:0] hot;
    logic [7:0] drain_hi;
  } ols_pins_t;

  // idle pin levels, so reset leaves no false edge behind
  localparam ols_pins_t PINS_RST = '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0,
                                     cmd0: 1'b0, cmd1: 1'b0, idle_n: 1'b1,
                                     kill: 1'b0, bat_low: 1'b0, lsup_ok: 1'b0,
                                     ovld: 8'h00, hot: 8'h00, drain_hi: 8'h00};

  typedef enum logic [1:0] {DG_IDLE, DG_PU, DG_PD} ols_diag_t;

endpackage
`default_nettype wire

// ---- ols_buf2.sv ----
`default_nettype none
module ols_buf2
  import ols_pkg::*;
#(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 2
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("buffer depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) wp_r <= wp_r + PW'(1);
      if (pop) rp_r <= rp_r + PW'(1);
      if (push && !pop) cnt_r <= cnt_r + (PW+1)'(1);
      else if (pop && !push) cnt_r <= cnt_r - (PW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ---- ols_top.sv ----
`default_nettype none
module ols_top
  import ols_pkg::*;
#(
  parameter int unsigned RETRY_CYC = RETRY_US * CLK_MHZ,
  parameter int unsigned BUF_DEPTH = 2
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         active_low_reset_pin_n,
  // serial link
  input  wire logic         spi_sclk,
  input  wire logic         spi_cs_n,
  input  wire logic         spi_si,
  output logic              spi_so,
  output logic              spi_so_oe,
  // control pins
  input  wire logic         parallel_cmd_input_zero,
  input  wire logic         parallel_cmd_input_one,
  input  wire logic         idle_pin_n,
  input  wire logic         output_kill_pin,
  input  wire logic         battery_supply_low,
  input  wire logic         logic_supply_ok,
  // power stage sense
  input  wire logic [7:0]   overload_sense,
  input  wire logic [7:0]   overtemp_sense,
  input  wire logic [7:0]   drain_high,
  // power stage drive
  output logic [7:0]        chan_on,
  output logic [7:0]        pull_up_en,
  output logic [7:0]        pull_down_en,
  output logic              limp_active,
  output logic              frame_rejected
);

  if (RETRY_CYC < 1) begin : g_chk_retry
    $error("retry count must be at least one cycle");
  end

  // ****************************************
  // pin synchronisers and internal reset
  // ****************************************
  ols_pins_t pin_m;
  ols_pins_t pin_s;
  ols_pins_t pin_raw;
  logic      sclk_d;
  logic      cs_d;
  logic      active_low_reset_pin_m;
  logic      active_low_reset_pin_s;
  logic      rst_i;

  assign pin_raw = '{sclk: spi_sclk, cs_n: spi_cs_n, si: spi_si,
                     cmd0: parallel_cmd_input_zero, cmd1: parallel_cmd_input_one,
                     idle_n: idle_pin_n, kill: output_kill_pin,
                     bat_low: battery_supply_low, lsup_ok: logic_supply_ok,
                     ovld: overload_sense, hot: overtemp_sense, drain_hi: drain_high};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_low_reset_pin_m <= 1'b0;
      active_low_reset_pin_s <= 1'b0;
    end else if (ce) begin
      active_low_reset_pin_m <= active_low_reset_pin_n;
      active_low_reset_pin_s <= active_low_reset_pin_m;
    end
  end

  assign rst_i = reset | ~active_low_reset_pin_s;

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      pin_m  <= PINS_RST;
      pin_s  <= PINS_RST;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else if (ce) begin
      pin_m  <= pin_raw;
      pin_s  <= pin_m;
      sclk_d <= pin_s.sclk;
      cs_d   <= pin_s.cs_n;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = pin_s.sclk & ~sclk_d;
  assign sclk_fall = ~pin_s.sclk & sclk_d;
  assign cs_fall   = ~pin_s.cs_n & cs_d;
  assign cs_rise   = pin_s.cs_n & ~cs_d;

  // ****************************************
  // shift path
  // ****************************************
  logic [15:0] sh_r;
  logic [4:0]  bits_r;
  ols_resp_t   tx_word_r;

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      sh_r      <= '0;
      bits_r    <= '0;
      spi_so    <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        sh_r      <= tx_word_r;
        bits_r    <= '0;
        spi_so    <= tx_word_r.err;
        spi_so_oe <= 1'b1;
      end else if (!pin_s.cs_n && sclk_rise) begin
        sh_r <= {sh_r[14:0], pin_s.si};
        if (bits_r != BITS_SAT) bits_r <= bits_r + 5'h01;
      end else if (!pin_s.cs_n && sclk_fall) begin
        spi_so <= sh_r[15];
      end
      if (cs_rise) spi_so_oe <= 1'b0;
    end
  end

  // ****************************************
  // frame check and buffer
  // ****************************************
  ols_frame_t rx;
  logic       rx_long;
  logic       rx_ok;
  logic [1:0] exp_cnt_r;
  logic       buf_in_ready;
  logic [15:0] buf_out;
  logic       buf_out_valid;
  logic       buf_out_ready;
  ols_frame_t fr;
  logic       fire;

  assign rx      = ols_frame_t'(sh_r);
  assign rx_long = (bits_r >= FRAME_BITS_C);
  assign rx_ok   = rx_long && (^sh_r) && (rx.cnt == exp_cnt_r);

  ols_buf2 #(
    .W     (FRAME_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .reset     (rst_i),
    .ce        (ce),
    .in_data   (sh_r),
    .in_valid  (cs_rise && rx_ok),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready)
  );

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      exp_cnt_r      <= '0;
      frame_rejected <= 1'b0;
    end else if (ce && cs_rise) begin
      if (rx_long) exp_cnt_r <= rx.cnt + 2'h1;
      frame_rejected <= !(rx_ok && buf_in_ready);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] spi_cmd_r;
  logic [7:0] map0_r;
  logic [7:0] map1_r;
  logic [7:0] pwm0_map_r;
  logic [7:0] pwm1_map_r;
  logic [7:0] duty_r;
  logic [7:0] cfg_r;
  logic [7:0] ovld_r;
  logic [7:0] hot_r;
  logic [7:0] open_r;
  logic [7:0] short_r;
  ols_diag_t  dg_r;
  logic       diag_go;
  logic       wr_fire;

  assign fr            = ols_frame_t'(buf_out);
  assign diag_go       = fr.wr && fr.addr == A_CFG && fr.data[B_DIAG_GO];
  assign buf_out_ready = !(diag_go && dg_r != DG_IDLE);
  assign fire          = buf_out_valid && buf_out_ready;
  assign wr_fire       = fire && fr.wr;

  function automatic logic [7:0] rd_val(input logic [3:0] a);
    unique case (a)
      A_OUT:   rd_val = spi_cmd_r;
      A_MAP0:  rd_val = map0_r;
      A_MAP1:  rd_val = map1_r;
      A_PWM0:  rd_val = pwm0_map_r;
      A_PWM1:  rd_val = pwm1_map_r;
      A_DUTY:  rd_val = duty_r;
      A_CFG:   rd_val = cfg_r;
      A_OVLD:  rd_val = ovld_r;
      A_HOT:   rd_val = hot_r;
      A_OPEN:  rd_val = open_r;
      A_SHORT: rd_val = short_r;
      A_STAT:  rd_val = {limp_active, pin_s.lsup_ok, pin_s.bat_low, pin_s.kill,
                         dg_r != DG_IDLE, 3'h0};
      default: rd_val = 8'h00;
    endcase
  endfunction

  function automatic ols_resp_t mk_resp(input logic e, input logic [3:0] a,
                                        input logic [1:0] c, input logic [7:0] d);
    mk_resp = '{err: e, addr: a, cnt: c, data: d, par: ~^{e, a, c, d}};
  endfunction

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      tx_word_r <= RESP_RST;
    end else if (ce) begin
      if (cs_rise && !(rx_ok && buf_in_ready)) begin
        tx_word_r <= mk_resp(1'b1, rx.addr, rx.cnt, 8'h00);
      end else if (fire) begin
        tx_word_r <= mk_resp(1'b0, fr.addr, fr.cnt, rd_val(fr.addr));
      end
    end
  end

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      spi_cmd_r  <= REG_RST;
      map0_r     <= MAP0_RST;
      map1_r     <= MAP1_RST;
      pwm0_map_r <= REG_RST;
      pwm1_map_r <= REG_RST;
      duty_r     <= REG_RST;
      cfg_r      <= REG_RST;
    end else if (ce && wr_fire) begin
      unique case (fr.addr)
        A_OUT:   spi_cmd_r  <= fr.data;
        A_MAP0:  map0_r     <= fr.data;
        A_MAP1:  map1_r     <= fr.data;
        A_PWM0:  pwm0_map_r <= fr.data;
        A_PWM1:  pwm1_map_r <= fr.data;
        A_DUTY:  duty_r     <= fr.data;
        A_CFG:   cfg_r      <= {1'b0, fr.data[6:0]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // pwm generators
  // ****************************************
  logic [31:0] pwm_div_r;
  logic [3:0]  phase_r;
  logic        pwm0;
  logic        pwm1;

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      pwm_div_r <= '0;
      phase_r   <= '0;
    end else if (ce) begin
      if (pwm_div_r == PWM_STEP_CYC - 1) begin
        pwm_div_r <= '0;
        phase_r   <= phase_r + 4'h1;
      end else begin
        pwm_div_r <= pwm_div_r + 32'h1;
      end
    end
  end

  assign pwm0 = phase_r < duty_r[3:0];
  assign pwm1 = phase_r < duty_r[7:4];

  // ****************************************
  // fault latches
  // ****************************************
  logic       limp;
  logic [7:0] clr_ovld;
  logic [7:0] clr_hot;
  logic [7:0] clr_open;
  logic [7:0] clr_short;
  logic [7:0] retry_clr;
  logic [7:0] set_open;
  logic [7:0] set_short;
  logic [31:0] retry_cnt_r [2];
  logic [1:0]  link;

  assign limp      = ~pin_s.idle_n;
  assign clr_ovld  = (wr_fire && fr.addr == A_OVLD) ? fr.data : 8'h00;
  assign clr_hot   = (wr_fire && fr.addr == A_HOT) ? fr.data : 8'h00;
  assign clr_open  = (wr_fire && fr.addr == A_OPEN) ? fr.data : 8'h00;
  assign clr_short = (wr_fire && fr.addr == A_SHORT) ? fr.data : 8'h00;
  assign link      = {pin_s.cmd1, pin_s.cmd0};

  always_comb begin
    retry_clr = 8'h00;
    retry_clr[LIMP_CH0] = limp && ovld_r[LIMP_CH0] && link[0]
                          && retry_cnt_r[0] == RETRY_CYC - 1;
    retry_clr[LIMP_CH1] = limp && ovld_r[LIMP_CH1] && link[1]
                          && retry_cnt_r[1] == RETRY_CYC - 1;
  end

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      retry_cnt_r[0] <= '0;
      retry_cnt_r[1] <= '0;
    end else if (ce) begin
      for (int k = 0; k < 2; k++) begin
        if (limp && link[k] && ovld_r[k == 0 ? LIMP_CH0 : LIMP_CH1]
            && retry_cnt_r[k] != RETRY_CYC - 1) begin
          retry_cnt_r[k] <= retry_cnt_r[k] + 32'h1;
        end else begin
          retry_cnt_r[k] <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      ovld_r  <= '0;
      hot_r   <= '0;
      open_r  <= '0;
      short_r <= '0;
    end else if (ce) begin
      ovld_r  <= (ovld_r & ~(clr_ovld | retry_clr)) | (pin_s.ovld & chan_on);
      hot_r   <= (hot_r & ~clr_hot) | (pin_s.hot & chan_on);
      open_r  <= (open_r & ~clr_open) | set_open;
      short_r <= (short_r & ~clr_short) | set_short;
    end
  end

  // ****************************************
  // off-state diagnosis
  // ****************************************
  logic [2:0]  dch_r;
  logic [31:0] dtmr_r;
  logic        step_end;
  logic [7:0]  dsel;

  assign step_end  = (dg_r != DG_IDLE) && dtmr_r == DIAG_STEP_CYC - 1;
  assign dsel      = 8'h01 << dch_r;
  assign set_short = (dg_r == DG_PU && step_end && !pin_s.drain_hi[dch_r]) ? dsel : 8'h00;
  assign set_open  = (dg_r == DG_PD && step_end && !pin_s.drain_hi[dch_r]) ? dsel : 8'h00;

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      dg_r         <= DG_IDLE;
      dch_r        <= '0;
      dtmr_r       <= '0;
      pull_up_en   <= '0;
      pull_down_en <= '0;
    end else if (ce) begin
      dtmr_r <= step_end ? 32'h0 : dtmr_r + 32'h1;
      unique case (dg_r)
        DG_IDLE: begin
          dtmr_r <= '0;
          if (fire && diag_go) begin
            dch_r      <= fr.data[B_DCH_LO +: 3];
            dg_r       <= DG_PU;
            pull_up_en <= 8'h01 << fr.data[B_DCH_LO +: 3];
          end
        end
        DG_PU: begin
          if (chan_on[dch_r]) begin
            dg_r       <= DG_IDLE;
            pull_up_en <= '0;
          end else if (step_end) begin
            dg_r         <= DG_PD;
            pull_up_en   <= '0;
            pull_down_en <= dsel;
          end
        end
        DG_PD: begin
          if (chan_on[dch_r] || step_end) begin
            dg_r         <= DG_IDLE;
            pull_down_en <= '0;
          end
        end
        default: begin
          dg_r         <= DG_IDLE;
          pull_up_en   <= '0;
          pull_down_en <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // output gating
  // ****************************************
  logic [7:0] cmd_norm;
  logic [7:0] cmd_limp;
  logic       uv_off;

  always_comb begin
    cmd_norm = spi_cmd_r | (map0_r & {8{pin_s.cmd0}}) | (map1_r & {8{pin_s.cmd1}})
             | (pwm0_map_r & {8{pwm0}}) | (pwm1_map_r & {8{pwm1}});
    cmd_limp = 8'h00;
    cmd_limp[LIMP_CH0] = pin_s.cmd0;
    cmd_limp[LIMP_CH1] = pin_s.cmd1;
  end

  assign uv_off = pin_s.bat_low && pin_s.lsup_ok && !cfg_r[B_UV_MASK];

  always_ff @(posedge clk or posedge rst_i) begin
    if (rst_i) begin
      chan_on     <= '0;
      limp_active <= 1'b0;
    end else if (ce) begin
      limp_active <= limp;
      if (pin_s.kill || uv_off) begin
        chan_on <= '0;
      end else begin
        chan_on <= (limp ? cmd_limp : (pin_s.lsup_ok ? cmd_norm : 8'h00))
                   & ~ovld_r & ~hot_r & ~pin_s.ovld;
      end
    end
  end
endmodule
`default_nettype wire

// ---- ols_chk.sv ----
`default_nettype none
module ols_chk
  import ols_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       active_low_reset_pin_n,
  // watched pins
  input wire logic       spi_cs_n,
  input wire logic       spi_so_oe,
  input wire logic       idle_pin_n,
  input wire logic       output_kill_pin,
  input wire logic [7:0] overload_sense,
  input wire logic [7:0] chan_on,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_down_en,
  input wire logic       limp_active,
  input wire logic       frame_rejected
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // helper logic
  // ****************************************
  logic [7:0]  ovl1_r;
  logic [7:0]  ovl2_r;
  logic [7:0]  ovl3_r;
  int unsigned pu_len_r;
  // overload held for three samples
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovl1_r <= 8'h00;
      ovl2_r <= 8'h00;
      ovl3_r <= 8'h00;
    end else begin
      ovl1_r <= overload_sense;
      ovl2_r <= ovl1_r & overload_sense;
      ovl3_r <= ovl2_r & overload_sense;
    end
  end
  // length of the pull-up step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pu_len_r <= 0;
    end else if (|pull_up_en) begin
      pu_len_r <= pu_len_r + 1;
    end else begin
      pu_len_r <= 0;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !active_low_reset_pin_n);
  sequence pu_end_s;
    $fell(|pull_up_en) ##0 (chan_on == 8'h00);
  endsequence
  sequence pd_go_s;
    ##[0:3] (pull_down_en != 8'h00);
  endsequence
  kill_off_a: assert property (output_kill_pin [*4] |-> chan_on == 8'h00)
    else $error("outputs on while kill pin high");
  ovl_off_a: assert property ((chan_on & ovl3_r) == 8'h00)
    else $error("channel on under lasting overload");
  pull_excl_a: assert property ($onehot0(pull_up_en | pull_down_en))
    else $error("more than one diag source on");
  pu_len_a: assert property (pu_end_s |-> pu_len_r == DIAG_STEP_CYC)
    else $error("pull-up step has wrong length");
  pd_next_a: assert property (pu_end_s |-> pd_go_s)
    else $error("pull-down step does not follow pull-up");
  oe_off_a: assert property (spi_cs_n [*5] |-> !spi_so_oe)
    else $error("serial out driven while deselected");
  rej_hold_a: assert property (!spi_cs_n [*6] |-> $stable(frame_rejected))
    else $error("reject flag moved inside a frame");
  limp_flag_a: assert property ($stable(idle_pin_n) [*6] |-> limp_active == !idle_pin_n)
    else $error("limp flag does not follow idle pin");
  limp_only_a: assert property (!idle_pin_n [*6] |-> (chan_on & 8'hF3) == 8'h00)
    else $error("channel other than two or three on in limp");
endmodule
bind ols_top ols_chk chk (.clk, .reset, .active_low_reset_pin_n, .spi_cs_n, .spi_so_oe,
  .idle_pin_n, .output_kill_pin, .overload_sense, .chan_on, .pull_up_en, .pull_down_en,
  .limp_active, .frame_rejected);
`default_nettype wire

// ---- ols_spi_host.sv ----
`default_nettype none
module ols_spi_host
  import ols_pkg::*;
(
  // clock
  input  wire logic clk,
  // serial link
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // ****************************************
  // frame exchange, msb first, mode 0
  // ****************************************
  // half period of 8 clk keeps sclk at 6.25 MHz
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
      si <= w[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      r = {r[30:0], so};
    end
    repeat (8) @(posedge clk);
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
  endtask
endmodule
`default_nettype wire

// ---- ols_top_test.sv ----
`default_nettype none
module ols_top_test
  import ols_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RETRY = 20;
  logic        clk = 1'b0, reset = 1'b1, pin_n = 1'b1, in0 = 1'b0, in1 = 1'b0;
  logic        idle_n = 1'b1, kill = 1'b0, bat_low = 1'b0, lsup = 1'b1;
  logic [7:0]  overload_fault = 8'h00, hot = 8'h00, drain = 8'hFF;
  logic        sclk, cs_n, si, so, so_oe, limp, rej;
  logic [7:0]  chan_on, pu, pd;
  logic [1:0]  cnt = 2'h0;
  logic [31:0] rsp;
  int          failures = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  ols_top #(.RETRY_CYC(RETRY)) dut (.clk, .reset, .ce(1'b1), .active_low_reset_pin_n(pin_n),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
    .parallel_cmd_input_zero(in0), .parallel_cmd_input_one(in1), .idle_pin_n(idle_n),
    .output_kill_pin(kill), .battery_supply_low(bat_low), .logic_supply_ok(lsup),
    .overload_sense(overload_fault), .overtemp_sense(hot), .drain_high(drain), .chan_on,
    .pull_up_en(pu), .pull_down_en(pd), .limp_active(limp), .frame_rejected(rej));
  ols_spi_host h (.clk, .sclk, .cs_n, .si, .so(so_oe ? so : ~so));
  // ****************************************
  // helpers
  // ****************************************
  task automatic print_verdict;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    chk_w({8'h00, g}, {8'h00, e});
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] fr(input logic w, input logic [3:0] a,
                                     input logic [1:0] c, input logic [7:0] d);
    fr = {w, a, c, d, 1'b0};
    fr[0] = ~^fr[15:1];
  endfunction
  task automatic sp(input logic wr, input logic [3:0] a, input logic [7:0] d);
    h.xfer({16'h0, fr(wr, a, cnt, d)}, 16, rsp);
    cnt = cnt + 2'h1;
    cy(20);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    logic [1:0] c;
    c = cnt;
    sp(1'b0, a, 8'h00);
    sp(1'b0, A_OUT, 8'h00);
    chk_w(rsp[15:0], fr(1'b0, a, c, d));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk_v(chan_on, 8'h00);
    sp(1'b0, A_OUT, 8'h00);
    chk_w(rsp[15:0], RESP_RST);
    rd(A_MAP0, MAP0_RST);
    rd(A_MAP1, MAP1_RST);
    @(posedge clk) in0 <= 1'b1;
    cy(6);
    chk_v(chan_on, 8'h04);
    @(posedge clk) in0 <= 1'b0;
    in1 <= 1'b1;
    cy(6);
    chk_v(chan_on, 8'h08);
    @(posedge clk) in1 <= 1'b0;
  endtask
  task automatic t_map;
    sp(1'b1, A_OUT, 8'h81);
    chk_v(chan_on, 8'h81);
    sp(1'b1, A_MAP0, 8'h70);
    sp(1'b1, A_OUT, 8'h00);
    @(posedge clk) in0 <= 1'b1;
    in1 <= 1'b1;
    cy(6);
    chk_v(chan_on, 8'h78);
    @(posedge clk) in0 <= 1'b0;
    in1 <= 1'b0;
    rd(A_MAP0, 8'h70);
  endtask
  task automatic t_chain;
    logic [1:0] c;
    c = cnt;
    h.xfer({8'h00, 8'hA5, fr(1'b1, A_OUT, cnt, 8'h02)}, 24, rsp);
    cnt = cnt + 2'h1;
    cy(20);
    chk_w({8'h00, rsp[7:0]}, 16'h00A5);
    chk_w(rsp[23:8], fr(1'b0, A_OUT, c - 2'h1, 8'h00));
    chk_v(chan_on, 8'h02);
  endtask
  task automatic t_reject;
    logic [15:0] f;
    for (int i = 0; i < 3; i++) begin
      f = fr(1'b1, A_OUT, cnt + 2'(i / 2), 8'hFF) ^ 16'(i == 1);
      h.xfer({16'h0, f} >> ((i == 0) ? 4 : 0), (i == 0) ? 12 : 16, rsp);
      cnt = cnt + 2'(i);
      cy(20);
      chk_v({7'h0, rej}, 8'h01);
      if (i > 0) chk_v({7'h0, rsp[15]}, 8'h01);
    end
    sp(1'b0, A_OUT, 8'h00);
    chk_v({7'h0, rsp[15]}, 8'h01);
    chk_v({7'h0, rej}, 8'h00);
    chk_v(chan_on, 8'h02);
  endtask
  task automatic t_kill;
    @(posedge clk) kill <= 1'b1;
    cy(6);
    chk_v(chan_on, 8'h00);
    @(posedge clk) kill <= 1'b0;
    bat_low <= 1'b1;
    cy(6);
    chk_v(chan_on, 8'h00);
    sp(1'b1, A_CFG, 8'h01);
    chk_v(chan_on, 8'h02);
    @(posedge clk) bat_low <= 1'b0;
    pin_n <= 1'b0;
    cy(6);
    chk_v(chan_on, 8'h00);
    @(posedge clk) pin_n <= 1'b1;
    cy(10);
    cnt = 2'h0;
    rd(A_OUT, REG_RST);
    rd(A_CFG, REG_RST);
  endtask
  task automatic t_ovl;
    sp(1'b1, A_OUT, 8'h01);
    @(posedge clk) overload_fault <= 8'h01;
    cy(6);
    @(posedge clk) overload_fault <= 8'h00;
    rd(A_OVLD, 8'h01);
    chk_v(chan_on, 8'h00);
    sp(1'b1, A_OVLD, 8'h01);
    chk_v(chan_on, 8'h01);
    @(posedge clk) hot <= 8'h01;
    cy(6);
    @(posedge clk) hot <= 8'h00;
    rd(A_HOT, 8'h01);
    chk_v(chan_on, 8'h00);
    sp(1'b1, A_HOT, 8'h01);
    sp(1'b1, A_OUT, 8'h00);
    sp(1'b1, A_MAP0, 8'h01);
    @(posedge clk) idle_n <= 1'b0;
    lsup <= 1'b0;
    in0 <= 1'b1;
    in1 <= 1'b1;
    cy(8);
    chk_v(chan_on, 8'h0C);
    chk_v({7'h0, limp}, 8'h01);
    @(posedge clk) overload_fault <= 8'h04;
    cy(6);
    @(posedge clk) overload_fault <= 8'h00;
    cy(4);
    chk_v(chan_on, 8'h08);
    cy(RETRY + 10);
    chk_v(chan_on, 8'h0C);
    @(posedge clk) idle_n <= 1'b1;
    lsup <= 1'b1;
    in0 <= 1'b0;
    in1 <= 1'b0;
    cy(8);
  endtask
  task automatic t_diag;
    sp(1'b1, A_CFG, 8'h8A);
    chk_v(pu, 8'h20);
    chk_v(pd, 8'h00);
    sp(1'b1, A_CFG, 8'h8A);
    sp(1'b1, A_MAP1, 8'h08);
    sp(1'b1, A_MAP1, 8'h08);
    chk_v({7'h0, rej}, 8'h01);
    repeat (3000) if (pd == 8'h00) cy(1);
    chk_v(pd, 8'h20);
    chk_v(pu, 8'h00);
    @(posedge clk) drain <= 8'hDF;
    cy(2010);
    rd(A_SHORT, 8'h00);
    rd(A_OPEN, 8'h20);
    cy(3500);
    chk_v(pu | pd, 8'h00);
    rd(A_SHORT, 8'h20);
  endtask
  task automatic t_pwm;
    int n0;
    int n1;
    n0 = 0;
    n1 = 0;
    sp(1'b1, A_PWM0, 8'h10);
    sp(1'b1, A_PWM1, 8'h40);
    sp(1'b1, A_DUTY, 8'h48);
    // one sample per pwm phase
    repeat (16) begin
      cy(PWM_STEP_CYC);
      n0 += chan_on[4];
      n1 += chan_on[6];
    end
    chk_v(8'(n0), 8'h08);
    chk_v(8'(n1), 8'h04);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    cy(8);
    t_reset;
    t_map;
    t_chain;
    t_reject;
    t_kill;
    t_ovl;
    t_diag;
    t_pwm;
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
